// ### logic/sdc_pkg.sv
// Constants, register map and state types for the SDRAM setup and start-up block
package sdc_pkg;
	localparam int CBUS_ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int INDEX_W = 8;
	localparam int NUM_BANKS = 4;
	localparam int ADDR_W = 13;
	localparam int CHECK_W = 8;
	localparam int READ_BUF_BYTES = 32;
	localparam int WRITE_BUF_BYTES = 128;
	localparam int OPEN_PAGES = 4;

	// Control bus addresses of the indirect pair
	localparam logic [CBUS_ADDR_W-1:0] CBUS_INDEX_ADDR = 10'h010;
	localparam logic [CBUS_ADDR_W-1:0] CBUS_WINDOW_ADDR = 10'h011;

	// Offsets reached through the window
	localparam logic [INDEX_W-1:0] OFS_SYND_A = 8'h00;
	localparam logic [INDEX_W-1:0] OFS_SYND_B = 8'h08;
	localparam logic [INDEX_W-1:0] OFS_BEAR = 8'h10;
	localparam logic [INDEX_W-1:0] OFS_CFG = 8'h20;
	localparam logic [INDEX_W-1:0] OFS_STATUS = 8'h24;
	localparam logic [INDEX_W-1:0] OFS_RTR = 8'h30;
	localparam logic [INDEX_W-1:0] OFS_PMIT = 8'h34;
	localparam logic [INDEX_W-1:0] OFS_BANK0 = 8'h40;
	localparam logic [INDEX_W-1:0] OFS_BANK1 = 8'h44;
	localparam logic [INDEX_W-1:0] OFS_BANK2 = 8'h48;
	localparam logic [INDEX_W-1:0] OFS_BANK3 = 8'h4C;
	localparam logic [INDEX_W-1:0] OFS_TR = 8'h80;
	localparam logic [INDEX_W-1:0] OFS_ECCCFG = 8'h94;
	localparam logic [INDEX_W-1:0] OFS_ECCESR = 8'h98;

	// Bit 0 of a register is its most significant bit, so vector index = 31 - bit
	localparam int CFG_CTRL_EN = 31;
	localparam int CFG_SELF_REFRESH = 30;
	localparam int CFG_POWER_MGMT = 29;
	localparam int CFG_ERR_CHECK = 28;
	localparam logic [DATA_W-1:0] CFG_WMASK = 32'hFFE0_0000;
	localparam int STAT_DONE = 31;
	localparam int BANK_BE = 0;
	localparam int BANK_SZ_LSB = 17;
	localparam logic [2:0] BANK_SZ_RESERVED = 3'h7;
	localparam int TR_CASL_LSB = 23;
	localparam int TR_PRECHARGE_WAIT_LSB = 18;
	localparam int TR_REFRESH_SPACING_LSB = 8;
	localparam int WAIT_W = 3;
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

	// Mode register word and precharge-all address bit
	localparam int MODE_CL_LSB = 4;
	localparam logic [2:0] MODE_BL_CODE = 3'h1;
	localparam logic [2:0] CL_OFFSET = 3'h1;
	localparam int PALL_ADDR_BIT = 10;
	localparam logic [3:0] INIT_REFRESHES = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PWAIT = 3'b001,
		ST_REF1 = 3'b010,
		ST_MRS = 3'b011,
		ST_REF2 = 3'b100,
		ST_READY = 3'b101
	} sdc_state_t;

	typedef enum logic [1:0] {
		CMD_NOP = 2'b00,
		CMD_PALL = 2'b01,
		CMD_REF = 2'b10,
		CMD_MRS = 2'b11
	} sdc_cmd_t;
endpackage

// ### logic/sdc_setup_init.sv
// SDRAM controller setup registers, pin reset states and power-up sequence
`timescale 1ns/1ps
module sdc_setup_init (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [sdc_pkg::CBUS_ADDR_W-1:0] cbus_addr_in,
	input wire logic cbus_read_in,
	input wire logic cbus_write_in,
	input wire logic [sdc_pkg::DATA_W-1:0] cbus_wdata_in,
	output logic [sdc_pkg::DATA_W-1:0] cbus_rdata_out,
	output logic cbus_ack_out,
	input wire logic err_capture_in,
	input wire logic err_to_b_in,
	input wire logic [sdc_pkg::DATA_W-1:0] err_syndrome_in,
	input wire logic [sdc_pkg::DATA_W-1:0] err_addr_in,
	input wire logic [sdc_pkg::DATA_W-1:0] ecc_status_in,
	output logic [1:0] mem_clock_out,
	output logic [1:0] mem_clock_enable_out,
	output logic [1:0] internal_bank_addr_out,
	output logic [sdc_pkg::ADDR_W-1:0] mem_row_col_addr_out,
	output logic [sdc_pkg::NUM_BANKS-1:0] physical_bank_select_n_out,
	output logic row_strobe_n_out,
	output logic col_strobe_n_out,
	output logic write_strobe_n_out,
	input wire logic [0:sdc_pkg::DATA_W-1] mem_data_bus_in,
	output logic [0:sdc_pkg::DATA_W-1] mem_data_bus_out,
	output logic mem_data_bus_oe_out,
	output logic [0:3] data_byte_mask_out,
	input wire logic [0:sdc_pkg::CHECK_W-1] check_bit_bus_in,
	output logic [0:sdc_pkg::CHECK_W-1] check_bit_bus_out,
	output logic check_bit_bus_oe_out,
	output logic check_bit_mask_out,
	output logic mem_ready_out,
	output logic ecc_select_out,
	output logic self_refresh_req_out,
	output logic power_mgmt_req_out
);
	import sdc_pkg::*;

	// Data path widths are fixed by the pin set; refuse anything else
	if (NUM_BANKS != 4 || DATA_W != 32 || CHECK_W != 8) begin : bad_pins
		$error("sdc_setup_init: pin widths must be 32 data, 8 check, 4 banks");
	end
	if (READ_BUF_BYTES != 32 || WRITE_BUF_BYTES != 128 || OPEN_PAGES > NUM_BANKS) begin : bad_buf
		$error("sdc_setup_init: buffer or page directory sizes unsupported");
	end

	logic ack_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [INDEX_W-1:0] index_reg;
	logic [DATA_W-1:0] cfg_reg;
	logic [DATA_W-1:0] timing_reg;
	logic [DATA_W-1:0] pmit_reg;
	logic [DATA_W-1:0] rtr_reg;
	logic [DATA_W-1:0] bear_reg;
	logic [DATA_W-1:0] ecccfg_reg;
	logic [DATA_W-1:0] eccesr_reg;
	logic [DATA_W-1:0] synd_a_reg;
	logic [DATA_W-1:0] synd_b_reg;
	logic [DATA_W-1:0] bank_cfg_reg [NUM_BANKS];
	logic done_reg;
	logic div_reg;
	sdc_state_t state_reg, state_next;
	logic [WAIT_W-1:0] wait_reg, wait_next;
	logic [3:0] refs_reg, refs_next;
	logic [1:0] bank_reg, bank_next;
	sdc_cmd_t cmd_next;
	logic set_done;

	logic take;
	logic win_wr;
	logic win_rd;
	logic ctrl_en;
	logic tick;
	logic [NUM_BANKS-1:0] bank_en;
	logic [WAIT_W-1:0] precharge_wait;
	logic [WAIT_W-1:0] refresh_spacing;
	logic [ADDR_W-1:0] mode_word;

	// Request taken once; a held request is not taken again while acked
	assign take = (cbus_read_in || cbus_write_in) && !ack_reg &&
		(cbus_addr_in == CBUS_INDEX_ADDR || cbus_addr_in == CBUS_WINDOW_ADDR);
	assign win_wr = take && cbus_write_in && cbus_addr_in == CBUS_WINDOW_ADDR;
	assign win_rd = take && cbus_read_in && cbus_addr_in == CBUS_WINDOW_ADDR;
	assign ctrl_en = cfg_reg[CFG_CTRL_EN];
	assign tick = div_reg;
	assign precharge_wait = {1'b0, timing_reg[TR_PRECHARGE_WAIT_LSB +: 2]};
	assign refresh_spacing = timing_reg[TR_REFRESH_SPACING_LSB +: WAIT_W];
	assign mode_word = ADDR_W'({3'(timing_reg[TR_CASL_LSB +: 2]) + CL_OFFSET, 1'b0, MODE_BL_CODE} << 0);

	// A bank takes part only if enabled and given a defined size
	always_comb begin
		for (int i = 0; i < NUM_BANKS; i++) begin
			bank_en[i] = bank_cfg_reg[i][BANK_BE] &&
				bank_cfg_reg[i][BANK_SZ_LSB +: 3] != BANK_SZ_RESERVED;
		end
	end

	function automatic logic [DATA_W-1:0] read_reg(input logic [INDEX_W-1:0] ofs);
		logic [DATA_W-1:0] v;
		v = REG_RESET;
		case (ofs)
			OFS_SYND_A: v = synd_a_reg;
			OFS_SYND_B: v = synd_b_reg;
			OFS_BEAR: v = bear_reg;
			OFS_CFG: v = cfg_reg;
			OFS_STATUS: v = {done_reg, {(DATA_W-1){1'b0}}};
			OFS_RTR: v = rtr_reg;
			OFS_PMIT: v = pmit_reg;
			OFS_BANK0: v = bank_cfg_reg[0];
			OFS_BANK1: v = bank_cfg_reg[1];
			OFS_BANK2: v = bank_cfg_reg[2];
			OFS_BANK3: v = bank_cfg_reg[3];
			OFS_TR: v = timing_reg;
			OFS_ECCCFG: v = ecccfg_reg;
			OFS_ECCESR: v = eccesr_reg;
			default: v = REG_RESET;
		endcase
		return v;
	endfunction

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_reg <= 1'b0;
			rdata_reg <= REG_RESET;
		end else begin
			ack_reg <= take;
			if (win_rd) begin
				rdata_reg <= read_reg(index_reg);
			end else if (take && cbus_read_in) begin
				rdata_reg <= {{(DATA_W-INDEX_W){1'b0}}, index_reg};
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			index_reg <= '0;
		end else if (take && cbus_write_in && cbus_addr_in == CBUS_INDEX_ADDR) begin
			index_reg <= cbus_wdata_in[INDEX_W-1:0];
		end
	end

	// Global config: never locked, reserved bits stay zero
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_reg <= REG_RESET;
		end else if (win_wr && index_reg == OFS_CFG) begin
			cfg_reg <= cbus_wdata_in & CFG_WMASK;
		end
	end

	// Timing, idle timer and bank setups hold while the controller is enabled
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			timing_reg <= REG_RESET;
			pmit_reg <= REG_RESET;
			for (int i = 0; i < NUM_BANKS; i++) begin
				bank_cfg_reg[i] <= REG_RESET;
			end
		end else if (win_wr && !ctrl_en) begin
			if (index_reg == OFS_TR) begin
				timing_reg <= cbus_wdata_in;
			end
			if (index_reg == OFS_PMIT) begin
				pmit_reg <= cbus_wdata_in;
			end
			for (int i = 0; i < NUM_BANKS; i++) begin
				if (index_reg == OFS_BANK0 + INDEX_W'(4 * i)) begin
					bank_cfg_reg[i] <= cbus_wdata_in;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rtr_reg <= REG_RESET;
			ecccfg_reg <= REG_RESET;
			eccesr_reg <= REG_RESET;
		end else begin
			eccesr_reg <= ecc_status_in;
			if (win_wr && index_reg == OFS_RTR) begin
				rtr_reg <= cbus_wdata_in;
			end
			if (win_wr && index_reg == OFS_ECCCFG) begin
				ecccfg_reg <= cbus_wdata_in;
			end
		end
	end

	// Write-one-to-clear syndromes; a capture in the same cycle wins
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			synd_a_reg <= REG_RESET;
			synd_b_reg <= REG_RESET;
			bear_reg <= REG_RESET;
		end else begin
			synd_a_reg <= (synd_a_reg & ~((win_wr && index_reg == OFS_SYND_A) ? cbus_wdata_in : REG_RESET)) |
				((err_capture_in && !err_to_b_in) ? err_syndrome_in : REG_RESET);
			synd_b_reg <= (synd_b_reg & ~((win_wr && index_reg == OFS_SYND_B) ? cbus_wdata_in : REG_RESET)) |
				((err_capture_in && err_to_b_in) ? err_syndrome_in : REG_RESET);
			if (err_capture_in) begin
				bear_reg <= err_addr_in;
			end else if (win_wr && index_reg == OFS_BEAR) begin
				bear_reg <= cbus_wdata_in;
			end
		end
	end

	// Memory clock is half the block clock; commands change on its falling edge
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_reg <= 1'b0;
		end else begin
			div_reg <= !div_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		wait_next = wait_reg;
		refs_next = refs_reg;
		bank_next = bank_reg;
		cmd_next = CMD_NOP;
		set_done = 1'b0;
		if (!ctrl_en) begin
			state_next = ST_IDLE;
		end else if (tick) begin
			case (state_reg)
				ST_IDLE: begin
					cmd_next = CMD_PALL;
					wait_next = precharge_wait;
					state_next = ST_PWAIT;
				end
				ST_PWAIT: begin
					if (wait_reg > WAIT_W'(1)) begin
						wait_next = wait_reg - 1'b1;
					end else begin
						cmd_next = CMD_REF;
						refs_next = INIT_REFRESHES - 4'h1;
						wait_next = refresh_spacing;
						state_next = ST_REF1;
					end
				end
				ST_REF1, ST_REF2: begin
					if (wait_reg > WAIT_W'(1)) begin
						wait_next = wait_reg - 1'b1;
					end else if (refs_reg != 4'h0) begin
						cmd_next = CMD_REF;
						refs_next = refs_reg - 4'h1;
						wait_next = refresh_spacing;
					end else if (state_reg == ST_REF1) begin
						bank_next = 2'h0;
						state_next = ST_MRS;
					end else begin
						state_next = ST_READY;
					end
				end
				ST_MRS: begin
					if (bank_en[bank_reg]) begin
						cmd_next = CMD_MRS;
					end
					bank_next = bank_reg + 2'h1;
					if (bank_reg == 2'(NUM_BANKS - 1)) begin
						set_done = 1'b1;
						refs_next = INIT_REFRESHES;
						wait_next = '0;
						state_next = ST_REF2;
					end
				end
				ST_READY: state_next = ST_READY;
				default: state_next = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ST_IDLE;
			wait_reg <= '0;
			refs_reg <= 4'h0;
			bank_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			refs_reg <= refs_next;
			bank_reg <= bank_next;
		end
	end

	// Done follows the enable down in the very next cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			done_reg <= 1'b0;
			mem_ready_out <= 1'b0;
		end else begin
			done_reg <= ctrl_en && (done_reg || set_done);
			mem_ready_out <= ctrl_en && state_next == ST_READY;
		end
	end

	// Command pins: one memory clock per command, inactive high otherwise
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			internal_bank_addr_out <= 2'h0;
			mem_row_col_addr_out <= '0;
			physical_bank_select_n_out <= '1;
			row_strobe_n_out <= 1'b1;
			col_strobe_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
		end else if (tick) begin
			internal_bank_addr_out <= 2'h0;
			mem_row_col_addr_out <= '0;
			physical_bank_select_n_out <= '1;
			row_strobe_n_out <= 1'b1;
			col_strobe_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			case (cmd_next)
				CMD_PALL: begin
					mem_row_col_addr_out[PALL_ADDR_BIT] <= 1'b1;
					physical_bank_select_n_out <= ~bank_en;
					row_strobe_n_out <= 1'b0;
					write_strobe_n_out <= 1'b0;
				end
				CMD_REF: begin
					physical_bank_select_n_out <= ~bank_en;
					row_strobe_n_out <= 1'b0;
					col_strobe_n_out <= 1'b0;
				end
				CMD_MRS: begin
					mem_row_col_addr_out <= mode_word;
					physical_bank_select_n_out <= ~(NUM_BANKS'(1) << bank_reg);
					row_strobe_n_out <= 1'b0;
					col_strobe_n_out <= 1'b0;
					write_strobe_n_out <= 1'b0;
				end
				CMD_NOP: row_strobe_n_out <= 1'b1;
				default: row_strobe_n_out <= 1'b1;
			endcase
		end
	end

	// No data transfers here: buses stay released and every byte masked
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mem_clock_out <= 2'h0;
			mem_clock_enable_out <= 2'h3;
			mem_data_bus_out <= '0;
			mem_data_bus_oe_out <= 1'b0;
			data_byte_mask_out <= 4'hF;
			check_bit_bus_out <= '0;
			check_bit_bus_oe_out <= 1'b0;
			check_bit_mask_out <= 1'b1;
			ecc_select_out <= 1'b0;
			self_refresh_req_out <= 1'b0;
			power_mgmt_req_out <= 1'b0;
		end else begin
			mem_clock_out <= {2{!div_reg}};
			mem_clock_enable_out <= 2'h3;
			mem_data_bus_out <= '0;
			mem_data_bus_oe_out <= 1'b0;
			data_byte_mask_out <= 4'hF;
			check_bit_bus_out <= '0;
			check_bit_bus_oe_out <= 1'b0;
			check_bit_mask_out <= 1'b1;
			ecc_select_out <= cfg_reg[CFG_ERR_CHECK];
			self_refresh_req_out <= cfg_reg[CFG_SELF_REFRESH];
			power_mgmt_req_out <= cfg_reg[CFG_POWER_MGMT];
		end
	end

	assign cbus_ack_out = ack_reg;
	assign cbus_rdata_out = rdata_reg;

	// Refresh counter read only by the checks below
	logic [4:0] ref_seen_reg;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ref_seen_reg <= 5'h0;
		end else if (state_reg == ST_IDLE) begin
			ref_seen_reg <= 5'h0;
		end else if (tick && cmd_next == CMD_REF) begin
			ref_seen_reg <= ref_seen_reg + 5'h1;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	index_write_a: assert property (take && cbus_write_in && cbus_addr_in == CBUS_INDEX_ADDR
		|=> index_reg == $past(cbus_wdata_in[INDEX_W-1:0]) && cbus_ack_out)
		else $error("index register not loaded");
	timing_lock_a: assert property (ctrl_en && win_wr && index_reg == OFS_TR |=> $stable(timing_reg))
		else $error("timing register changed while enabled");
	cfg_write_a: assert property (win_wr && index_reg == OFS_CFG |=> cfg_reg == ($past(cbus_wdata_in) & CFG_WMASK))
		else $error("global config write lost");
	quiet_disabled_a: assert property (!ctrl_en [*3] |-> row_strobe_n_out && col_strobe_n_out && write_strobe_n_out)
		else $error("command issued while disabled");
	pin_reset_a: assert property (mem_clock_enable_out == 2'h3 && !mem_data_bus_oe_out && !check_bit_bus_oe_out
		&& data_byte_mask_out == 4'hF && check_bit_mask_out)
		else $error("pin reset state violated");
	precharge_first_a: assert property (state_reg == ST_IDLE && ctrl_en && tick
		|=> !row_strobe_n_out && col_strobe_n_out && !write_strobe_n_out && mem_row_col_addr_out[PALL_ADDR_BIT])
		else $error("start-up did not begin with precharge all");
	first_burst_a: assert property ($rose(state_reg == ST_MRS) |-> ref_seen_reg == 5'h8)
		else $error("first refresh burst not eight");
	second_burst_a: assert property ($rose(state_reg == ST_READY) |-> ref_seen_reg == 5'h10)
		else $error("second refresh burst not eight");
	mode_bank_a: assert property (!row_strobe_n_out && !col_strobe_n_out && !write_strobe_n_out
		|-> $onehot(~physical_bank_select_n_out) && (~physical_bank_select_n_out & bank_en) != '0)
		else $error("mode write to disabled bank");
	done_clear_a: assert property ($fell(ctrl_en) |=> !done_reg)
		else $error("done bit survived disable");
	synd_set_wins_a: assert property (err_capture_in && !err_to_b_in |=> (synd_a_reg & $past(err_syndrome_in))
		== $past(err_syndrome_in))
		else $error("syndrome capture lost");

	reach_ready_c: cover property ($rose(mem_ready_out));
	locked_write_c: cover property (ctrl_en && win_wr && index_reg == OFS_BANK0);
	abort_init_c: cover property ($fell(ctrl_en) && state_reg == ST_REF1);
	synd_clear_c: cover property (win_wr && index_reg == OFS_SYND_A && synd_a_reg != REG_RESET);
endmodule

// ### verif/sdc_mem_model.sv
// Behavioural SDRAM side: decodes start-up commands and drives the released data lines
`timescale 1ns/1ps
module sdc_mem_model (
	input wire logic mclk_in,
	input wire logic [3:0] sel_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [12:0] addr_in,
	output logic [0:31] data_out,
	output logic [0:7] check_out,
	output int pall_out,
	output int ref_out,
	output int mrs_out,
	output logic [3:0] mrs_sel_out,
	output logic [12:0] mrs_addr_out
);
	initial begin
		data_out = 32'h5555_5555;
		check_out = 8'h55;
		pall_out = 0;
		ref_out = 0;
		mrs_out = 0;
		mrs_sel_out = 4'h0;
		mrs_addr_out = 13'h0;
	end

	// No pull on these lines, so a released bus shows a pattern that flips every cycle
	always @(posedge mclk_in) begin
		data_out <= ~data_out;
		check_out <= ~check_out;
		if (sel_n_in != 4'hF) begin
			case ({ras_n_in, cas_n_in, we_n_in})
				3'b010: if (addr_in[10]) pall_out <= pall_out + 1;
				3'b001: ref_out <= ref_out + 1;
				3'b000: begin
					mrs_out <= mrs_out + 1;
					mrs_sel_out <= mrs_sel_out | ~sel_n_in;
					mrs_addr_out <= addr_in;
				end
				default: ;
			endcase
		end
	end
endmodule

// ### verif/test_sdram_ctrl_setup_init.sv
// Self-checking bench for the SDRAM setup and start-up block
`timescale 1ns/1ps
module test_sdram_ctrl_setup_init;
	import sdc_pkg::*;
	typedef struct packed {logic [7:0] ofs; logic [31:0] wr; logic [31:0] exp;} sdc_row_t;
	logic clk_in, rstn_in, cbus_read_in, cbus_write_in, cbus_ack_out, err_capture_in, err_to_b_in;
	logic [9:0] cbus_addr_in;
	logic [31:0] cbus_wdata_in, cbus_rdata_out, err_syndrome_in, err_addr_in, ecc_status_in, rd;
	logic [1:0] mem_clock_out, mem_clock_enable_out, internal_bank_addr_out;
	logic [12:0] mem_row_col_addr_out, m_addr;
	logic [3:0] physical_bank_select_n_out, m_sel;
	logic row_strobe_n_out, col_strobe_n_out, write_strobe_n_out, mem_data_bus_oe_out;
	logic check_bit_bus_oe_out, check_bit_mask_out, mem_ready_out, ecc_select_out;
	logic self_refresh_req_out, power_mgmt_req_out;
	logic [0:31] mem_data_bus_in, mem_data_bus_out;
	logic [0:3] data_byte_mask_out;
	logic [0:7] check_bit_bus_in, check_bit_bus_out;
	int pall, refs, mrs, fail_count, checks_done, i, n;
	localparam logic [31:0] IDLE_PINS = {2'h3, 15'h0, 4'hF, 3'h7, 2'h0, 4'hF, 2'h2};
	sdc_row_t rows [13] = '{
		'{OFS_RTR, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
		'{OFS_PMIT, 32'h1234_5678, 32'h1234_5678},
		'{OFS_BANK0, 32'h0000_0001, 32'h0000_0001},
		'{OFS_BANK1, 32'h000E_0001, 32'h000E_0001},
		'{OFS_BANK2, 32'h0000_0001, 32'h0000_0001},
		'{OFS_BANK3, 32'h00AA_0000, 32'h00AA_0000},
		'{OFS_TR, 32'h0084_0100, 32'h0084_0100},
		'{OFS_ECCCFG, 32'hCAFE_F00D, 32'hCAFE_F00D},
		'{OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000},
		'{8'h50, 32'hFFFF_FFFF, 32'h0000_0000},
		'{OFS_ECCESR, 32'hFFFF_FFFF, 32'h0000_3C00},
		'{OFS_BEAR, 32'h0BAD_CAFE, 32'h0BAD_CAFE},
		'{OFS_CFG, 32'h7FFF_FFFF, 32'h7FE0_0000}
	};

	sdc_setup_init dut_u (.clk_in, .rstn_in, .cbus_addr_in, .cbus_read_in, .cbus_write_in, .cbus_wdata_in,
		.cbus_rdata_out, .cbus_ack_out, .err_capture_in, .err_to_b_in, .err_syndrome_in, .err_addr_in,
		.ecc_status_in, .mem_clock_out, .mem_clock_enable_out, .internal_bank_addr_out,
		.mem_row_col_addr_out, .physical_bank_select_n_out, .row_strobe_n_out, .col_strobe_n_out,
		.write_strobe_n_out, .mem_data_bus_in, .mem_data_bus_out, .mem_data_bus_oe_out, .data_byte_mask_out,
		.check_bit_bus_in, .check_bit_bus_out, .check_bit_bus_oe_out, .check_bit_mask_out, .mem_ready_out,
		.ecc_select_out, .self_refresh_req_out, .power_mgmt_req_out);

	sdc_mem_model mem_u (.mclk_in(mem_clock_out[0]), .sel_n_in(physical_bank_select_n_out),
		.ras_n_in(row_strobe_n_out), .cas_n_in(col_strobe_n_out), .we_n_in(write_strobe_n_out),
		.addr_in(mem_row_col_addr_out), .data_out(mem_data_bus_in), .check_out(check_bit_bus_in),
		.pall_out(pall), .ref_out(refs), .mrs_out(mrs), .mrs_sel_out(m_sel), .mrs_addr_out(m_addr));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	function automatic logic [31:0] pins();
		return {mem_clock_enable_out, internal_bank_addr_out, mem_row_col_addr_out, physical_bank_select_n_out,
			row_strobe_n_out, col_strobe_n_out, write_strobe_n_out, mem_data_bus_oe_out, check_bit_bus_oe_out,
			data_byte_mask_out, check_bit_mask_out, 1'b0};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Request is held until the edge that samples ack, then dropped at that edge as ack falls
	task automatic bus_xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		cbus_addr_in <= a;
		cbus_wdata_in <= d;
		cbus_write_in <= wr;
		cbus_read_in <= !wr;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (cbus_ack_out !== 1'b1 && k < 6);
		rd = cbus_rdata_out;
		chk({31'h0, cbus_ack_out}, {31'h0, a[9:1] == 9'h008});
		cbus_write_in <= 1'b0;
		cbus_read_in <= 1'b0;
	endtask

	task automatic reg_wr(input logic [7:0] ofs, input logic [31:0] d);
		bus_xfer(1'b1, CBUS_INDEX_ADDR, {24'h0, ofs});
		bus_xfer(1'b1, CBUS_WINDOW_ADDR, d);
	endtask

	task automatic reg_rd(input logic [7:0] ofs);
		bus_xfer(1'b1, CBUS_INDEX_ADDR, {24'h0, ofs});
		bus_xfer(1'b0, CBUS_WINDOW_ADDR, 32'h0);
	endtask

	initial begin
		#500us;
		fail_count++;
		end_of_test();
	end

	initial begin
		rstn_in = 1'b0;
		{cbus_read_in, cbus_write_in, err_capture_in, err_to_b_in} = 4'h0;
		cbus_addr_in = 10'h0;
		cbus_wdata_in = 32'h0;
		err_syndrome_in = 32'h0;
		err_addr_in = 32'h0;
		ecc_status_in = 32'h0000_3C00;
		fail_count = 0;
		checks_done = 0;
		repeat (6) @(posedge clk_in);
		chk(pins(), IDLE_PINS);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		chk(pins(), IDLE_PINS);
		chk(mem_data_bus_out, 32'h0);
		chk({24'h0, check_bit_bus_out}, 32'h0);
		// Both clock copies rise together one cycle after release
		@(posedge clk_in);
		chk({30'h0, mem_clock_out}, 32'h3);
		for (i = 0; i < 13; i++) begin
			reg_wr(rows[i].ofs, rows[i].wr);
			reg_rd(rows[i].ofs);
			chk(rd, rows[i].exp);
		end
		bus_xfer(1'b0, CBUS_INDEX_ADDR, 32'h0);
		chk(rd, {24'h0, OFS_CFG});
		chk({29'h0, ecc_select_out, self_refresh_req_out, power_mgmt_req_out}, 32'h7);
		chk(32'(pall + refs + mrs), 32'h0);
		chk({31'h0, mem_ready_out}, 32'h0);
		bus_xfer(1'b1, 10'h012, 32'h1);
		reg_wr(OFS_CFG, 32'h0);
		repeat (20) @(posedge clk_in);
		reg_rd(OFS_CFG);
		reg_wr(OFS_CFG, (rd & ~32'h8000_0000) | 32'h8000_0000);
		n = 0;
		while (mem_ready_out !== 1'b1 && n < 600) begin
			@(posedge clk_in);
			n++;
		end
		chk({31'h0, mem_ready_out}, 32'h1);
		chk(32'(pall), 32'h1);
		chk(32'(refs), 32'd16);
		chk(32'(mrs), 32'h2);
		chk({28'h0, m_sel}, 32'h5);
		chk({19'h0, m_addr}, 32'h21);
		reg_rd(OFS_STATUS);
		chk(rd, 32'h8000_0000);
		for (i = 1; i < 7; i++) begin
			reg_wr(rows[i].ofs, 32'h0);
			reg_rd(rows[i].ofs);
			chk(rd, rows[i].exp);
		end
		reg_wr(OFS_CFG, 32'h0);
		repeat (2) @(posedge clk_in);
		chk({31'h0, mem_ready_out}, 32'h0);
		reg_rd(OFS_STATUS);
		chk(rd, 32'h0);
		repeat (4) @(posedge clk_in);
		chk(pins(), IDLE_PINS);
		reg_wr(OFS_TR, 32'h0);
		reg_rd(OFS_TR);
		chk(rd, 32'h0);
		@(posedge clk_in);
		err_capture_in <= 1'b1;
		err_syndrome_in <= 32'h0000_00F0;
		err_addr_in <= 32'h1234_0000;
		@(posedge clk_in);
		err_syndrome_in <= 32'h0000_0F00;
		@(posedge clk_in);
		err_to_b_in <= 1'b1;
		err_syndrome_in <= 32'h0000_0001;
		@(posedge clk_in);
		err_capture_in <= 1'b0;
		reg_rd(OFS_SYND_A);
		chk(rd, 32'h0000_0FF0);
		reg_rd(OFS_SYND_B);
		chk(rd, 32'h0000_0001);
		reg_rd(OFS_BEAR);
		chk(rd, 32'h1234_0000);
		reg_wr(OFS_SYND_A, 32'h0000_00F0);
		reg_rd(OFS_SYND_A);
		chk(rd, 32'h0000_0F00);
		reg_wr(OFS_CFG, 32'h8000_0000);
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk(pins(), IDLE_PINS);
		rstn_in <= 1'b1;
		reg_rd(OFS_CFG);
		chk(rd, 32'h0);
		end_of_test();
	end
endmodule
